//--- rtl/omc_top.sv
// Paged operation and margin-low registers with target selection and slewed reference
// Summary of operation
// - Margin field zero selects the nominal voltage target.
// - Upper margin bits 01 select the margin-low target register.
// - Upper margin bits 10 select the margin-high target.
// - Lower bits 01 suppress over/undervoltage faults during margining.
// - Lower bits 10 keep over/undervoltage faults active during margining.
// - Margin and on bits obeyed only when configured to respect operation byte.
// - Reference ramps toward new target at the configured slew rate.
// - On bit zero disables conversion, one permits it, when required.
// - On bit combined with channel enable pin; other conditions must also hold.
// - Page 00h channel A, 01h channel B, FFh writes both.
// - Operation byte accepted only by byte-sized transfers.
// - Margin-low is a word; upper byte read-only zero.
// - Act-on-fault margin above nominal sets the maximum-voltage warning.
module omc_top
    import omc_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter logic [6:0] DEV_ADDR = 7'h5a  // Arbitrary bus address
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Management bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Enable pins
    input wire logic channel_a_enable_pin,
    input wire logic channel_b_enable_pin,
    // Other voltage settings
    input wire logic [7:0] nominal_voltage_target_a,
    input wire logic [7:0] nominal_voltage_target_b,
    input wire logic [7:0] margin_high_voltage_target_a,
    input wire logic [7:0] margin_high_voltage_target_b,
    input wire logic [7:0] voltage_slew_setting_a,
    input wire logic [7:0] voltage_slew_setting_b,
    input wire logic [7:0] voltage_control_source,
    // On/off configuration and start conditions
    input wire logic [1:0] cfg_use_on_bit,
    input wire logic [1:0] cfg_use_enable_pin,
    input wire logic [1:0] start_conditions_ok,
    // Status
    input wire logic [1:0] max_warn_clear,
    output logic [1:0] max_voltage_warning_flag,
    // Regulation outputs
    output logic [7:0] voltage_reference_a,
    output logic [7:0] voltage_reference_b,
    output logic [1:0] conversion_enable,
    output logic [1:0] fault_detect_enable
);
    import omc_pkg::*;

    if (NUM_CH != 2)
        $error("omc_top serves exactly two channels");

    // ************************************************************
    // Bus slave and transaction capture
    // ************************************************************
    logic wr_valid, xfer_stop;
    logic [7:0] wr_data, rd_data;
    logic [2:0] wr_idx, rd_idx;

    omc_bus_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
        .mclk(mclk),
        .resetn(resetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .wr_valid(wr_valid),
        .wr_data(wr_data),
        .wr_idx(wr_idx),
        .xfer_stop(xfer_stop),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    logic [7:0] page, next_page, cmd, next_cmd, d0, next_d0, d1, next_d1;
    logic [2:0] dcnt, next_dcnt;
    logic op_wr, margl_wr;

    // Data is only committed at the stop, so an over- or under-length transfer is dropped
    assign op_wr = xfer_stop && cmd == CMD_OPERATION && dcnt == BYTE_XFER;
    assign margl_wr = xfer_stop && cmd == CMD_MARGIN_LOW && dcnt == WORD_XFER;

    always_comb
    begin
        next_page = page;
        next_cmd = cmd;
        next_d0 = d0;
        next_d1 = d1;
        next_dcnt = dcnt;
        if (wr_valid)
        begin
            if (wr_idx == 3'h0)
            begin
                next_cmd = wr_data;
                next_dcnt = 3'h0;
            end
            else
            begin
                if (wr_idx == BYTE_XFER)
                    next_d0 = wr_data;
                if (wr_idx == WORD_XFER)
                    next_d1 = wr_data;
                if (dcnt != CNT_MAX)
                    next_dcnt = dcnt + 3'h1;
            end
        end
        if (xfer_stop)
        begin
            next_dcnt = 3'h0;
            if (cmd == CMD_PAGE && dcnt == BYTE_XFER
                && (d0 == PAGE_A || d0 == PAGE_B || d0 == PAGE_ALL))
                next_page = d0;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            page <= PAGE_RESET;
            cmd <= 8'h00;
            d0 <= 8'h00;
            d1 <= 8'h00;
            dcnt <= 3'h0;
        end
        else
        begin
            page <= next_page;
            cmd <= next_cmd;
            d0 <= next_d0;
            d1 <= next_d1;
            dcnt <= next_dcnt;
        end
    end

    // ************************************************************
    // Enable pin synchronisers
    // ************************************************************
    logic [1:0] en_s1, en_s2;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_s1 <= 2'h0;
            en_s2 <= 2'h0;
        end
        else
        begin
            en_s1 <= {channel_b_enable_pin, channel_a_enable_pin};
            en_s2 <= en_s1;
        end
    end

    // ************************************************************
    // Per-channel registers, target selection and slew
    // ************************************************************
    logic [1:0][7:0] nom_v, mhigh_v, slew_v, op_v, margl_v, ref_v;
    assign nom_v = {nominal_voltage_target_b, nominal_voltage_target_a};
    assign mhigh_v = {margin_high_voltage_target_b, margin_high_voltage_target_a};
    assign slew_v = {voltage_slew_setting_b, voltage_slew_setting_a};

    for (genvar g = 0; g < 2; g++)
    begin : g_ch
        logic [7:0] op_q, next_op, margl_q, next_margl, ref_q, next_ref, tgt;
        logic [15:0] tick, next_tick, period;
        logic warn, next_warn, sel, honour, margin_on, active;
        logic [1:0] msel, flt;

        // Page FFh selects both channels for writes
        assign sel = (page == PAGE_ALL) || (page == 8'(g));
        assign honour = cfg_use_on_bit[g];
        // Margining is obeyed only while the bus owns the output voltage
        assign margin_on = honour && voltage_control_source == SRC_BUS;
        assign msel = op_q[MARGIN_MSB -: 2];
        assign flt = op_q[MARGIN_LSB +: 2];
        assign active = margin_on && (msel == MSEL_LOW || msel == MSEL_HIGH);

        always_comb
        begin
            if (margin_on && msel == MSEL_LOW)
                tgt = margl_q;
            else if (margin_on && msel == MSEL_HIGH)
                tgt = mhigh_v[g];
            else
                tgt = nom_v[g];
        end

        // Ignore-faults masks detection; act-on-faults and no margining leave it on
        assign fault_detect_enable[g] = !(active && flt == FLT_IGNORE);
        assign conversion_enable[g] = (!honour || op_q[OP_ON_BIT])
            && (!cfg_use_enable_pin[g] || en_s2[g])
            && start_conditions_ok[g];

        assign period = 16'((17'(slew_v[g]) + 17'h1) * 17'(SLEW_UNIT_CYC));

        always_comb
        begin
            next_op = op_q;
            next_margl = margl_q;
            next_tick = tick;
            next_ref = ref_q;
            next_warn = warn;
            if (op_wr && sel)
                next_op = d0 & OP_WRITE_MASK;
            if (margl_wr && sel)
                next_margl = d0;
            if (ref_q == tgt)
                next_tick = 16'h0;
            else if (tick + 16'h1 >= period)
            begin
                // One code step per period; the ramp never jumps
                next_tick = 16'h0;
                next_ref = (ref_q < tgt) ? ref_q + 8'h1 : ref_q - 8'h1;
            end
            else
                next_tick = tick + 16'h1;
            if (max_warn_clear[g])
                next_warn = 1'b0;
            // Placed after the clear so a coincident event survives it
            if (active && flt == FLT_ACT && tgt > nom_v[g])
                next_warn = 1'b1;
        end

        always_ff @(posedge mclk or negedge resetn)
        begin
            if (!resetn)
            begin
                op_q <= OP_RESET;
                margl_q <= MARGL_RESET;
                tick <= 16'h0;
                ref_q <= REF_RESET;
                warn <= 1'b0;
            end
            else
            begin
                op_q <= next_op;
                margl_q <= next_margl;
                tick <= next_tick;
                ref_q <= next_ref;
                warn <= next_warn;
            end
        end

        assign op_v[g] = op_q;
        assign margl_v[g] = margl_q;
        assign ref_v[g] = ref_q;
        assign max_voltage_warning_flag[g] = warn;
    end

    assign voltage_reference_a = ref_v[0];
    assign voltage_reference_b = ref_v[1];

    // ************************************************************
    // Read data
    // ************************************************************
    logic rch;
    // Page FFh reads back channel A
    assign rch = (page == PAGE_B);

    always_comb
    begin
        rd_data = READ_FILL;
        case (cmd)
            CMD_PAGE:
                if (rd_idx == 3'h0)
                    rd_data = page;
            CMD_OPERATION:
                if (rd_idx == 3'h0)
                    rd_data = op_v[rch];
            CMD_MARGIN_LOW:
                if (rd_idx == 3'h0)
                    rd_data = margl_v[rch];
                else if (rd_idx == 3'h1)
                    rd_data = UPPER_ZERO;
            default: rd_data = READ_FILL;
        endcase
    end

endmodule : omc_top

//--- rtl/omc_pkg.sv
// Constants, encodings and states shared by the output margin control block
package omc_pkg;

    // ************************************************************
    // Command codes and paging
    // ************************************************************
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
    localparam logic [7:0] PAGE_A = 8'h00;
    localparam logic [7:0] PAGE_B = 8'h01;
    localparam logic [7:0] PAGE_ALL = 8'hff;
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // ************************************************************
    // Operation byte layout
    // ************************************************************
    localparam int OP_ON_BIT = 7;
    localparam int MARGIN_MSB = 5;
    localparam int MARGIN_LSB = 2;
    localparam logic [7:0] OP_WRITE_MASK = 8'hbf;
    localparam logic [7:0] OP_RESET = 8'h00;
    localparam logic [1:0] MSEL_LOW = 2'h1;
    localparam logic [1:0] MSEL_HIGH = 2'h2;
    localparam logic [1:0] FLT_IGNORE = 2'h1;
    localparam logic [1:0] FLT_ACT = 2'h2;

    // ************************************************************
    // Transfer sizes, fills and reset values
    // ************************************************************
    localparam logic [2:0] BYTE_XFER = 3'h1;
    localparam logic [2:0] WORD_XFER = 3'h2;
    localparam logic [2:0] CNT_MAX = 3'h7;
    localparam logic [7:0] READ_FILL = 8'hff;
    localparam logic [7:0] UPPER_ZERO = 8'h00;
    localparam logic [7:0] MARGL_RESET = 8'h00;
    localparam logic [7:0] REF_RESET = 8'h00;
    localparam logic [7:0] SRC_BUS = 8'h01;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int SLEW_UNIT_NS = 1000;
    localparam logic [15:0] SLEW_UNIT_CYC = 16'(SLEW_UNIT_NS / CLK_PERIOD_NS);

    // ************************************************************
    // Bus slave states
    // ************************************************************
    typedef enum logic [4:0] {
        OMC_IDLE = 5'h01,
        OMC_RECV = 5'h02,
        OMC_ACK = 5'h04,
        OMC_SEND = 5'h08,
        OMC_RACK = 5'h10
    } omc_sl_e;

endpackage : omc_pkg

//--- rtl/omc_bus_slave.sv
// Byte-level management bus slave with oversampled clock and data lines
module omc_bus_slave
    import omc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h5a  // Arbitrary bus address
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Byte interface
    output logic wr_valid,
    output logic [7:0] wr_data,
    output logic [2:0] wr_idx,
    output logic xfer_stop,
    output logic [2:0] rd_idx,
    input wire logic [7:0] rd_data
);
    import omc_pkg::*;

    // ************************************************************
    // Line synchronisers and edge detection
    // ************************************************************
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            {sda_s1, sda_s2, sda_d} <= 3'h7;
        end
        else
        begin
            {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
        end
    end

    logic rise, fall, start, stop;
    assign rise = scl_s2 & ~scl_d;
    assign fall = ~scl_s2 & scl_d;
    assign start = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop = scl_s2 & scl_d & ~sda_d & sda_s2;

    // ************************************************************
    // Protocol state
    // ************************************************************
    omc_sl_e st, next_st;
    logic [2:0] bitc, next_bitc, idx, next_idx, ridx, next_ridx;
    logic [7:0] shreg, next_shreg, wd, next_wd;
    logic full, next_full, is_addr, next_is_addr, rw, next_rw, oe, next_oe;
    logic wv, next_wv, stp, next_stp;

    always_comb
    begin
        next_st = st;
        next_bitc = bitc;
        next_idx = idx;
        next_ridx = ridx;
        next_shreg = shreg;
        next_wd = wd;
        next_full = full;
        next_is_addr = is_addr;
        next_rw = rw;
        next_oe = oe;
        next_wv = 1'b0;
        next_stp = 1'b0;
        if (start)
        begin
            // A repeated start keeps the command latched in the register bank
            next_st = OMC_RECV;
            next_bitc = 3'h0;
            next_full = 1'b0;
            next_is_addr = 1'b1;
            next_idx = 3'h0;
            next_oe = 1'b0;
        end
        else if (stop)
        begin
            next_st = OMC_IDLE;
            next_oe = 1'b0;
            next_stp = (st != OMC_IDLE);
        end
        else
        begin
            case (st)
                OMC_IDLE: ;
                OMC_RECV:
                begin
                    if (rise && !full)
                    begin
                        next_shreg = {shreg[6:0], sda_s2};
                        next_bitc = bitc + 3'h1;
                        next_full = (bitc == CNT_MAX);
                    end
                    if (fall && full)
                    begin
                        next_full = 1'b0;
                        if (!is_addr)
                        begin
                            next_wv = 1'b1;
                            next_wd = shreg;
                            next_oe = 1'b1;
                            next_st = OMC_ACK;
                        end
                        else if (shreg[7:1] == DEV_ADDR)
                        begin
                            next_rw = shreg[0];
                            next_ridx = 3'h0;
                            next_oe = 1'b1;
                            next_st = OMC_ACK;
                        end
                        else
                            next_st = OMC_IDLE;
                    end
                end
                OMC_ACK:
                begin
                    if (fall)
                    begin
                        next_bitc = 3'h0;
                        if (is_addr && rw)
                        begin
                            next_shreg = rd_data;
                            next_oe = ~rd_data[7];
                            next_st = OMC_SEND;
                        end
                        else
                        begin
                            if (!is_addr && idx != CNT_MAX)
                                next_idx = idx + 3'h1;
                            next_oe = 1'b0;
                            next_st = OMC_RECV;
                        end
                        next_is_addr = 1'b0;
                    end
                end
                OMC_SEND:
                begin
                    if (fall)
                    begin
                        if (bitc == CNT_MAX)
                        begin
                            next_oe = 1'b0;
                            next_st = OMC_RACK;
                        end
                        else
                        begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_oe = ~shreg[6];
                            next_bitc = bitc + 3'h1;
                        end
                    end
                end
                OMC_RACK:
                begin
                    // The index moves at the ack's rise so rd_data settles by the fall
                    if (rise)
                    begin
                        if (sda_s2)
                            next_st = OMC_IDLE;
                        else
                        begin
                            next_full = 1'b1;
                            if (ridx != CNT_MAX)
                                next_ridx = ridx + 3'h1;
                        end
                    end
                    if (fall && full)
                    begin
                        next_full = 1'b0;
                        next_bitc = 3'h0;
                        next_shreg = rd_data;
                        next_oe = ~rd_data[7];
                        next_st = OMC_SEND;
                    end
                end
                default: next_st = OMC_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= OMC_IDLE;
            bitc <= 3'h0;
            idx <= 3'h0;
            ridx <= 3'h0;
            shreg <= 8'h00;
            wd <= 8'h00;
            full <= 1'b0;
            is_addr <= 1'b0;
            rw <= 1'b0;
            oe <= 1'b0;
            wv <= 1'b0;
            stp <= 1'b0;
        end
        else
        begin
            st <= next_st;
            bitc <= next_bitc;
            idx <= next_idx;
            ridx <= next_ridx;
            shreg <= next_shreg;
            wd <= next_wd;
            full <= next_full;
            is_addr <= next_is_addr;
            rw <= next_rw;
            oe <= next_oe;
            wv <= next_wv;
            stp <= next_stp;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = oe;
    assign wr_valid = wv;
    assign wr_data = wd;
    assign wr_idx = idx;
    assign xfer_stop = stp;
    assign rd_idx = ridx;

endmodule : omc_bus_slave

//--- tb/omc_top_chk.sv
// Port-level assertions for the output margin control block
module omc_top_chk
    import omc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Watched ports
    input wire logic channel_a_enable_pin,
    input wire logic [7:0] voltage_control_source,
    input wire logic [1:0] cfg_use_on_bit,
    input wire logic [1:0] cfg_use_enable_pin,
    input wire logic [1:0] start_conditions_ok,
    input wire logic [1:0] max_warn_clear,
    input wire logic [1:0] max_voltage_warning_flag,
    input wire logic [7:0] voltage_reference_a,
    input wire logic [1:0] conversion_enable,
    input wire logic [1:0] fault_detect_enable
);
    // ********
    // Properties
    // ********
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_start_gate: assert property (!start_conditions_ok[0] [*3] |-> !conversion_enable[0])
        else $error("conversion without start conditions");
    // Four samples cover the pin synchroniser
    a_pin_gate: assert property ((cfg_use_enable_pin[0] && !channel_a_enable_pin) [*4]
        |-> !conversion_enable[0]) else $error("conversion with enable pin low");
    a_onbit_free: assert property ((!cfg_use_on_bit[1] && !cfg_use_enable_pin[1]
        && start_conditions_ok[1]) [*2] |-> conversion_enable[1])
        else $error("on bit obeyed while not configured");
    a_fault_cause: assert property (!fault_detect_enable[0]
        |-> cfg_use_on_bit[0] && voltage_control_source == SRC_BUS)
        else $error("faults masked without margin control");
    a_warn_cause: assert property ($rose(max_voltage_warning_flag[0])
        |-> $past(fault_detect_enable[0])) else $error("warning without act on faults");
    a_warn_hold: assert property ($fell(max_voltage_warning_flag[0])
        |-> $past(max_warn_clear[0])) else $error("warning dropped without clear");
    a_ref_step: assert property ($changed(voltage_reference_a)
        |-> voltage_reference_a - $past(voltage_reference_a) inside {8'h01, 8'hff})
        else $error("reference jumped");
    a_ref_pace: assert property ($changed(voltage_reference_a)
        |=> $stable(voltage_reference_a) [*8]) else $error("reference stepped too fast");
endmodule : omc_top_chk

bind omc_top omc_top_chk omc_top_chk_inst (.mclk, .resetn, .channel_a_enable_pin,
    .voltage_control_source, .cfg_use_on_bit, .cfg_use_enable_pin, .start_conditions_ok,
    .max_warn_clear, .max_voltage_warning_flag, .voltage_reference_a, .conversion_enable,
    .fault_detect_enable);

//--- tb/omc_host.sv
// Management bus host model: open-drain master that bit-bangs frames
module omc_host
(
    // Bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock idles high and stands still between frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ********
    // Bus cycles, 80 ns clock period
    // ********
    task automatic start_c();
        sda_low = 1'b0;
        #20 scl = 1'b1;
        #20 sda_low = 1'b1;
        #20 scl = 1'b0;
        #20;
    endtask : start_c
    task automatic stop_c();
        sda_low = 1'b1;
        #20 scl = 1'b1;
        #20 sda_low = 1'b0;
        #40;
    endtask : stop_c
    task automatic bit_c(input logic b, output logic r);
        sda_low = !b;
        #20 scl = 1'b1;
        #20 r = sda;
        #20 scl = 1'b0;
        #20;
    endtask : bit_c
    // Whole bytes only, most significant bit first
    task automatic byte_c(input logic [7:0] w, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) bit_c(w[i], r[i]);
    endtask : byte_c
endmodule : omc_host

//--- tb/tb_omc_top.sv
// Self-checking bench for the output margin control block
module tb_omc_top;
    timeunit 1ns;
    timeprecision 100ps;
    import omc_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0, sda_oe, scl_in, sda_low, nak, ack;
    logic channel_a_enable_pin = 1'b1, channel_b_enable_pin = 1'b0;
    logic [7:0] nominal_voltage_target_a = 8'h08, nominal_voltage_target_b = 8'h06;
    logic [7:0] margin_high_voltage_target_a = 8'h0c, margin_high_voltage_target_b = 8'h0a;
    logic [7:0] voltage_slew_setting_a = 8'h00, voltage_slew_setting_b = 8'h00;
    logic [7:0] voltage_control_source = SRC_BUS;
    logic [1:0] cfg_use_on_bit = 2'h3, cfg_use_enable_pin = 2'h1, start_conditions_ok = 2'h3;
    logic [1:0] max_warn_clear = 2'h0, max_voltage_warning_flag, conversion_enable;
    logic [1:0] fault_detect_enable;
    logic [7:0] voltage_reference_a, voltage_reference_b, r8;
    logic [15:0] d;
    int compares = 0, miscompares = 0, cycles = 0;
    // Pull-up: the line is low only while someone pulls it
    wire sda_in = !(sda_low || sda_oe);

    omc_host omc_host_inst (.scl(scl_in), .sda_low(sda_low), .sda(sda_in));
    omc_top omc_top_inst (.*, .sda_out());

    initial forever #4 mclk = !mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    // ********
    // Tasks
    // ********
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wait_ref(input logic [7:0] v);
        for (int k = 0; k < 3000 && voltage_reference_a !== v; k++) @(posedge mclk);
        #1;
        check(voltage_reference_a, v);
    endtask : wait_ref
    task automatic snd(input logic [7:0] b);
        omc_host_inst.byte_c(b, r8);
        omc_host_inst.bit_c(1'b1, ack);
        nak |= ack;
    endtask : snd
    task automatic wr(input logic [7:0] cmd, input logic [15:0] v, input int n);
        nak = 1'b0;
        omc_host_inst.start_c();
        snd(8'hb4);
        snd(cmd);
        for (int i = 0; i < n; i++) snd(v[8*i+:8]);
        omc_host_inst.stop_c();
        check({7'h0, nak}, 8'h00);
    endtask : wr
    task automatic rd(input logic [7:0] cmd, input int n);
        omc_host_inst.start_c();
        snd(8'hb4);
        snd(cmd);
        omc_host_inst.start_c();
        snd(8'hb5);
        for (int i = 0; i < n; i++)
        begin
            omc_host_inst.byte_c(8'hff, r8);
            omc_host_inst.bit_c(i == n - 1, ack);
            d[8*i+:8] = r8;
        end
        omc_host_inst.stop_c();
    endtask : rd
    // ********
    // Main sequence
    // ********
    initial
    begin
        tick(10);
        resetn = 1'b1;
        tick(3);
        rd(CMD_OPERATION, 1);
        check(d[7:0], OP_RESET);
        wr(CMD_MARGIN_LOW, 16'hab04, 2);
        rd(CMD_MARGIN_LOW, 2);
        check(d[7:0], 8'h04);
        check(d[15:8], UPPER_ZERO);
        wr(CMD_OPERATION, 16'h00ff, 1);
        rd(CMD_OPERATION, 1);
        check(d[7:0], 8'hbf);
        wait_ref(8'h08);
        wr(CMD_OPERATION, 16'h0094, 1);
        tick(20);
        check(voltage_reference_a, 8'h08);
        wait_ref(8'h04);
        check({7'h0, fault_detect_enable[0]}, 8'h00);
        check({7'h0, conversion_enable[0]}, 8'h01);
        start_conditions_ok = 2'h2;
        tick(4);
        check({7'h0, conversion_enable[0]}, 8'h00);
        start_conditions_ok = 2'h3;
        channel_a_enable_pin = 1'b0;
        tick(5);
        check({7'h0, conversion_enable[0]}, 8'h00);
        channel_a_enable_pin = 1'b1;
        wr(CMD_OPERATION, 16'h00a4, 1);
        wait_ref(8'h0c);
        wr(CMD_OPERATION, 16'h00a8, 1);
        tick(5);
        check({7'h0, fault_detect_enable[0]}, 8'h01);
        check({7'h0, max_voltage_warning_flag[0]}, 8'h01);
        wr(CMD_OPERATION, 16'h0080, 1);
        wait_ref(8'h08);
        max_warn_clear = 2'h1;
        tick(1);
        max_warn_clear = 2'h0;
        tick(1);
        check({7'h0, max_voltage_warning_flag[0]}, 8'h00);
        check({7'h0, conversion_enable[0]}, 8'h01);
        wr(CMD_OPERATION, 16'h0000, 1);
        tick(3);
        check({7'h0, conversion_enable[0]}, 8'h00);
        wr(CMD_OPERATION, 16'h8080, 2);
        rd(CMD_OPERATION, 1);
        check(d[7:0], 8'h00);
        wr(CMD_PAGE, {8'h00, PAGE_ALL}, 1);
        wr(CMD_MARGIN_LOW, 16'h0010, 2);
        wr(CMD_PAGE, {8'h00, PAGE_B}, 1);
        rd(CMD_MARGIN_LOW, 2);
        check(d[7:0], 8'h10);
        wr(CMD_OPERATION, 16'h0080, 1);
        tick(3);
        check({7'h0, conversion_enable[1]}, 8'h01);
        check(voltage_reference_b, 8'h06);
        cfg_use_on_bit = 2'h1;
        wr(CMD_OPERATION, 16'h0000, 1);
        tick(3);
        check({7'h0, conversion_enable[1]}, 8'h01);
        wr(CMD_PAGE, {8'h00, PAGE_A}, 1);
        rd(CMD_MARGIN_LOW, 2);
        check(d[7:0], 8'h10);
        rd(8'h55, 1);
        check(d[7:0], READ_FILL);
        end_of_test();
    end
endmodule : tb_omc_top
